/* verif/sbt_jtag_host.sv */
// ====
// Board tester model
module sbt_jtag_host (
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input wire logic  tdo_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// Clock parked low outside frames
	initial
	begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end
	// One 32 ns period; tdo read just before the rise
	task automatic step(input logic m, input logic d, output logic q);
		tms_o = m;
		tdi_o = d;
		#8;
		q = tdo_i;
		tck_o = 1'b1;
		#16;
		tck_o = 1'b0;
		#8;
	endtask : step
	task automatic scan(input logic ir, input int n, input logic [111:0] din,
		output logic [111:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir)
			step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		tms_o = 1'b1;
	endtask : scan
endmodule : sbt_jtag_host

/* verif/sbt_tap_monitor.sv */
// ====
// Port checks
module sbt_tap_monitor #(
	parameter logic [2:0]  PART_REV    = 3'h0,
	parameter logic [16:0] PART_CFG    = 17'h00000,
	parameter logic [10:0] VENDOR_CODE = 11'h155
) (
	input wire logic         clk_i,
	input wire logic         rst_i,
	input wire logic         tck_i,
	input wire logic         tms_i,
	input wire logic         tdi_i,
	input wire logic [107:0] balls_i,
	input wire logic         tdo_o,
	input wire logic         tdo_oe_o,
	input wire logic         out_float_o,
	input wire logic         test_drive_o,
	input wire logic [107:0] test_pins_o
);
	// Next state tables, nibble n for state n
	localparam logic [63:0] ON1 = 64'h2FEFCC0287855920;
	localparam logic [63:0] ON0 = 64'h1BDDBBA146644311;
	logic [3:0] st;
	logic [3:0] nx;
	logic [2:0] ir;
	logic [2:0] ir_sh;
	logic       upd;
	assign nx = tms_i ? ON1[st*4 +: 4] : ON0[st*4 +: 4];
	assign upd = st == sbt_pkg::ST_UPD_DR || st == sbt_pkg::ST_UPD_IR
		|| st == sbt_pkg::ST_RESET;
	always_ff @(posedge tck_i)
	begin
		if (rst_i)
		begin
			st    <= sbt_pkg::ST_RESET;
			ir    <= 3'h1;
			ir_sh <= 3'h0;
		end
		else
		begin
			st <= nx;
			if (st == sbt_pkg::ST_SH_IR)
				ir_sh <= {tdi_i, ir_sh[2:1]};
			if (nx == sbt_pkg::ST_UPD_IR)
				ir <= ir_sh;
			else if (st == sbt_pkg::ST_RESET)
				ir <= 3'h1;
		end
	end
	chk_tdo_fall: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(tdo_o) |-> !tck_i) else $error("tdo moved with tck high");
	chk_oe_shift: assert property (@(posedge tck_i) disable iff (rst_i)
		tdo_oe_o == (st == sbt_pkg::ST_SH_DR || st == sbt_pkg::ST_SH_IR))
		else $error("tdo enable outside shift");
	chk_ir_capture: assert property (@(posedge tck_i) disable iff (rst_i)
		st == sbt_pkg::ST_CAP_IR && !tms_i |=> tdo_o)
		else $error("instruction capture lsb not 1");
	chk_id_start: assert property (@(posedge tck_i) disable iff (rst_i)
		st == sbt_pkg::ST_CAP_DR && ir == 3'h1 && !tms_i |=> tdo_o)
		else $error("identity start bit not 1");
	chk_skip_path: assert property (@(posedge tck_i) disable iff (rst_i)
		st == sbt_pkg::ST_SH_DR && ir inside {3'h3, 3'h5, 3'h6, 3'h7}
		&& !tms_i |=> tdo_o == $past(tdi_i)) else $error("skip path delay");
	chk_pins_hold: assert property (@(posedge tck_i) disable iff (rst_i)
		!(upd || $past(upd) || $past(upd, 2)) |-> $stable(test_pins_o))
		else $error("pins moved without update");
	chk_drive_ir: assert property (@(posedge tck_i) disable iff (rst_i)
		st == sbt_pkg::ST_UPD_IR |-> ##2 test_drive_o == (ir == 3'h0))
		else $error("drive flag wrong after update");
	chk_float_ins: assert property (@(posedge tck_i) disable iff (rst_i)
		st == sbt_pkg::ST_UPD_IR && ir == 3'h2 |-> ##2 out_float_o)
		else $error("float sample not floating");
	chk_tms_reset: assert property (@(posedge tck_i) disable iff (rst_i)
		tms_i [*5] |-> ##3 !test_drive_o && !out_float_o)
		else $error("five high samples did not reset");
	cov_ext: cover property (@(posedge tck_i) st == 4'h4 && ir == 3'h0);
	cov_rst: cover property (@(posedge tck_i) tms_i [*5]);
	cov_flt: cover property (@(posedge clk_i) test_drive_o && out_float_o);
endmodule : sbt_tap_monitor

bind sbt_tap_top sbt_tap_monitor #(.PART_REV(PART_REV), .PART_CFG(PART_CFG),
	.VENDOR_CODE(VENDOR_CODE)) u_mon (.clk_i(clk_i), .rst_i(rst_i),
	.tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i), .balls_i(balls_i),
	.tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o), .out_float_o(out_float_o),
	.test_drive_o(test_drive_o), .test_pins_o(test_pins_o));

/* verif/sbt_tap_top_tb.sv */
module sbt_tap_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// Identity fields, values arbitrary
	localparam logic [2:0]  REV  = 3'h5;
	localparam logic [16:0] CFG  = 17'h0A5C3;
	localparam logic [10:0] VEND = 11'h2C3;
	logic         clk_i, rst_i, tck, tms, tdi, tdo, oe, flt, drv, line;
	logic [107:0] balls, pins;
	logic [2:0]   m_ir;
	logic [108:0] m_latch;
	logic [31:0]  seed = 32'h6086B700;
	int           err_count;
	int           n_tests;
	// Undriven tdo shows the inverse, never a stale bit
	assign line = oe ? tdo : !tdo;
	sbt_tap_top #(.PART_REV(REV), .PART_CFG(CFG), .VENDOR_CODE(VEND)) uut (
		.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.balls_i(balls), .tdo_o(tdo), .tdo_oe_o(oe), .out_float_o(flt),
		.test_drive_o(drv), .test_pins_o(pins));
	sbt_jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(line));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input string what, input logic [111:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic summarize();
		$display("tests %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic settle();
		repeat (10) @(posedge clk_i);
		chk("outputs", {drv, flt, pins}, {m_ir == 3'h0,
			m_ir == 3'h2 || (m_ir == 3'h0 && !m_latch[108]),
			m_latch[107:0]});
	endtask : settle
	task automatic run(input logic [2:0] code, input bit load);
		logic [111:0] din, dout, exp;
		logic [108:0] cap;
		bit           q[$];
		int           len;
		@(posedge clk_i);
		#1 balls = 108'({xs(), xs(), xs(), xs()});
		if (load)
		begin
			host.scan(1'b1, 3, 112'(code), dout);
			chk("ir_capture", dout[2:0], 3'h1);
			m_ir = code;
		end
		len = 1;
		cap = '0;
		if (m_ir inside {3'h0, 3'h2, 3'h4})
		begin
			len = 109;
			cap = {m_latch[108], balls};
		end
		else if (m_ir == 3'h1)
		begin
			len = 32;
			cap = 109'({REV, CFG, VEND, 1'b1});
		end
		for (int i = 0; i < len; i++)
			q.push_back(cap[i]);
		din = 112'({xs(), xs(), xs(), xs()});
		host.scan(1'b0, 112, din, dout);
		for (int i = 0; i < 112; i++)
		begin
			exp[i] = q.pop_front();
			q.push_back(din[i]);
		end
		chk("dr_shift", dout, exp);
		if (len == 109)
			for (int i = 0; i < 109; i++)
				m_latch[i] = q[i];
		settle();
		$display("test code %0d done", code);
	endtask : run
	initial
	begin
		clk_i = 1'b0;
		forever
			#5 clk_i = ~clk_i;
	end
	initial
	begin
		repeat (30000) @(posedge clk_i);
		err_count++;
		summarize();
	end
	initial
	begin
		logic q;
		rst_i = 1'b1;
		balls = '0;
		m_ir = 3'h1;
		m_latch = '0;
		err_count = 0;
		n_tests = 0;
		// Test side resets only with its clock running
		repeat (4) host.step(1'b1, 1'b1, q);
		@(posedge clk_i);
		#1 rst_i = 1'b0;
		repeat (5) host.step(1'b1, 1'b1, q);
		host.step(1'b0, 1'b1, q);
		chk("after_reset", {oe, drv, flt, pins}, 112'h0);
		run(3'h1, 1'b0);
		// Reserved codes are never loaded; skip takes their turn
		for (int p = 0; p < 2; p++)
			for (int c = 0; c < 8; c++)
				run((3'(c) inside {3'h3, 3'h5, 3'h6}) ? 3'h7 : 3'(c),
					1'b1);
		run(3'h0, 1'b1);
		repeat (5) host.step(1'b1, 1'b1, q);
		host.step(1'b0, 1'b1, q);
		m_ir = 3'h1;
		// Only the float cell is preset; preload bits keep their value
		m_latch[108] = 1'b0;
		settle();
		run(3'h1, 1'b0);
		summarize();
	end
endmodule : sbt_tap_top_tb

/* verilog/sbt_pkg.sv */
package sbt_pkg;

	// ==========================================================
	// Widths
	// ==========================================================
	localparam int IR_W   = 3;
	localparam int RING_W = 109;
	localparam int BALL_W = 108;
	localparam int ID_W   = 32;
	localparam int XFER_W = IR_W + RING_W;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int FLOAT_CELL = 108;
	localparam int ID_REV_LSB = 29;
	localparam int ID_CFG_LSB = 12;
	localparam int ID_VND_LSB = 1;

	// ==========================================================
	// Instruction codes
	// ==========================================================
	localparam logic [2:0] INS_EXTEST       = 3'h0;
	localparam logic [2:0] INS_IDREAD       = 3'h1;
	localparam logic [2:0] INS_FLOAT_SAMPLE = 3'h2;
	localparam logic [2:0] INS_SAMPLE       = 3'h4;
	localparam logic [2:0] INS_SKIP         = 3'h7;

	// ==========================================================
	// Values after reset and capture
	// ==========================================================
	localparam logic [2:0]        IR_RESET_VAL     = INS_IDREAD;
	localparam logic [2:0]        IR_CAPTURE_VAL   = 3'h1;
	localparam logic              SKIP_CAPTURE_VAL = 1'h0;
	localparam logic              FLOAT_CELL_RESET = 1'h0;
	localparam logic              ID_START_BIT     = 1'h1;
	localparam logic [RING_W-1:0] RING_RESET_VAL   = {RING_W{1'b0}};
	localparam logic [XFER_W-1:0] XFER_RESET_VAL   =
		{IR_RESET_VAL, RING_RESET_VAL};

	// ==========================================================
	// Controller states
	// ==========================================================
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE,
		ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR,
		ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
		ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
		ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
	} sbt_tap_state_t;

	// ==========================================================
	// Instruction decode
	// ==========================================================
	function automatic logic ring_selected(input logic [2:0] ins);
		return (ins == INS_EXTEST) || (ins == INS_FLOAT_SAMPLE)
			|| (ins == INS_SAMPLE);
	endfunction : ring_selected

	function automatic logic outputs_float(input logic [2:0] ins,
		input logic float_cell);
		return (ins == INS_FLOAT_SAMPLE)
			|| ((ins == INS_EXTEST) && !float_cell);
	endfunction : outputs_float

endpackage : sbt_pkg

/* verilog/sbt_tap_top.sv */
// How it works
// - Sample on rising, launch on falling edge
// - Mode input sampled on rising edges
// - Shift in at MSB, out at LSB
// - Serial output driven only in shift states
// - Five high mode samples reach reset
// - Reset by rst_i through a test-clock synchroniser, output floats
// - One register selected by current instruction
// - Three-bit instruction, takes effect at update
// - Reset loads identification-read instruction
// - Capture loads 01 into instruction LSBs
// - One-bit skip register, cleared when selected
// - Ring captures ball states, then shifts
// - Three instructions route through pin ring
// - Float-sample holds outputs floating until update
// - Fixed 32-bit identity captured and shifted
// - Sample and preload shift together; update latches
// - External test drives latched values out
// - Cell 109 gates output drivers, high drives
// - Float cell preset low at reset
// - Identity: revision, config, vendor, start bit
module sbt_tap_top #(
	parameter logic [2:0]  PART_REV    = 3'h0,
	parameter logic [16:0] PART_CFG    = 17'h00000,
	// Arbitrary vendor code
	parameter logic [10:0] VENDOR_CODE = 11'h155
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      tck_i,
	input  wire logic                      tms_i,
	input  wire logic                      tdi_i,
	input  wire logic [sbt_pkg::BALL_W-1:0] balls_i,
	output logic                           tdo_o,
	output logic                           tdo_oe_o,
	output logic                           out_float_o,
	output logic                           test_drive_o,
	output logic [sbt_pkg::BALL_W-1:0]     test_pins_o
);

	// ==========================================================
	// Test-clock reset and pin synchronisers
	// ==========================================================
	logic                        rst_meta_reg;
	logic                        rst_sync_reg;
	logic [sbt_pkg::BALL_W-1:0]  ball_meta_reg;
	logic [sbt_pkg::BALL_W-1:0]  ball_sync_reg;

	// The controller needs a few test-clock edges under rst_i to
	// settle; without them the five-high-edges reset still works.
	always_ff @(posedge tck_i)
	begin
		rst_meta_reg <= rst_i;
		rst_sync_reg <= rst_meta_reg;
	end

	// Balls are asynchronous to the test clock
	always_ff @(posedge tck_i)
	begin
		ball_meta_reg <= balls_i;
		ball_sync_reg <= ball_meta_reg;
	end

	// ==========================================================
	// Controller state machine
	// ==========================================================
	sbt_pkg::sbt_tap_state_t state_reg;
	sbt_pkg::sbt_tap_state_t state_next;

	// A run of five high samples from any state reaches reset
	always_comb
	begin
		case (state_reg)
			sbt_pkg::ST_RESET:
				state_next = tms_i ? sbt_pkg::ST_RESET
					: sbt_pkg::ST_IDLE;
			sbt_pkg::ST_IDLE:
				state_next = tms_i ? sbt_pkg::ST_SEL_DR
					: sbt_pkg::ST_IDLE;
			sbt_pkg::ST_SEL_DR:
				state_next = tms_i ? sbt_pkg::ST_SEL_IR
					: sbt_pkg::ST_CAP_DR;
			sbt_pkg::ST_CAP_DR:
				state_next = tms_i ? sbt_pkg::ST_EX1_DR
					: sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_SH_DR:
				state_next = tms_i ? sbt_pkg::ST_EX1_DR
					: sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_EX1_DR:
				state_next = tms_i ? sbt_pkg::ST_UPD_DR
					: sbt_pkg::ST_PAU_DR;
			sbt_pkg::ST_PAU_DR:
				state_next = tms_i ? sbt_pkg::ST_EX2_DR
					: sbt_pkg::ST_PAU_DR;
			sbt_pkg::ST_EX2_DR:
				state_next = tms_i ? sbt_pkg::ST_UPD_DR
					: sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_UPD_DR:
				state_next = tms_i ? sbt_pkg::ST_SEL_DR
					: sbt_pkg::ST_IDLE;
			sbt_pkg::ST_SEL_IR:
				state_next = tms_i ? sbt_pkg::ST_RESET
					: sbt_pkg::ST_CAP_IR;
			sbt_pkg::ST_CAP_IR:
				state_next = tms_i ? sbt_pkg::ST_EX1_IR
					: sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_SH_IR:
				state_next = tms_i ? sbt_pkg::ST_EX1_IR
					: sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_EX1_IR:
				state_next = tms_i ? sbt_pkg::ST_UPD_IR
					: sbt_pkg::ST_PAU_IR;
			sbt_pkg::ST_PAU_IR:
				state_next = tms_i ? sbt_pkg::ST_EX2_IR
					: sbt_pkg::ST_PAU_IR;
			sbt_pkg::ST_EX2_IR:
				state_next = tms_i ? sbt_pkg::ST_UPD_IR
					: sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_UPD_IR:
				state_next = tms_i ? sbt_pkg::ST_SEL_DR
					: sbt_pkg::ST_IDLE;
			default:
				state_next = sbt_pkg::ST_RESET;
		endcase
	end

	always_ff @(posedge tck_i)
	begin
		if (rst_sync_reg)
			state_reg <= sbt_pkg::ST_RESET;
		else
			state_reg <= state_next;
	end

	// ==========================================================
	// State and instruction decode
	// ==========================================================
	logic [2:0]                 ir_reg;
	logic [2:0]                 ir_shift_reg;
	logic                       skip_reg;
	logic [sbt_pkg::RING_W-1:0] ring_shift_reg;
	logic [sbt_pkg::RING_W-1:0] ring_latch_reg;
	logic [sbt_pkg::ID_W-1:0]   ident_shift_reg;
	logic                       was_reset_reg;
	logic                       toggle_reg;

	wire in_reset;
	wire cap_ir;
	wire sh_ir;
	wire upd_ir;
	wire cap_dr;
	wire sh_dr;
	wire upd_dr;
	wire ring_sel;
	wire id_sel;
	wire skip_sel;
	wire dr_out;
	wire tdo_next;
	wire tdo_oe_next;
	wire reset_entry;
	wire [sbt_pkg::ID_W-1:0] id_value;

	assign in_reset = state_reg == sbt_pkg::ST_RESET;
	assign cap_ir   = state_reg == sbt_pkg::ST_CAP_IR;
	assign sh_ir    = state_reg == sbt_pkg::ST_SH_IR;
	assign upd_ir   = state_reg == sbt_pkg::ST_UPD_IR;
	assign cap_dr   = state_reg == sbt_pkg::ST_CAP_DR;
	assign sh_dr    = state_reg == sbt_pkg::ST_SH_DR;
	assign upd_dr   = state_reg == sbt_pkg::ST_UPD_DR;

	// Reserved codes fall back to the skip bit, never an open path
	assign ring_sel = sbt_pkg::ring_selected(ir_reg);
	assign id_sel   = ir_reg == sbt_pkg::INS_IDREAD;
	assign skip_sel = !ring_sel && !id_sel;

	assign id_value = {PART_REV, PART_CFG, VENDOR_CODE,
		sbt_pkg::ID_START_BIT};

	// Only the selected register reaches the serial output
	assign dr_out = ring_sel ? ring_shift_reg[0]
		: (id_sel ? ident_shift_reg[0] : skip_reg);
	assign tdo_next    = sh_ir ? ir_shift_reg[0] : dr_out;
	assign tdo_oe_next = sh_ir || sh_dr;
	assign reset_entry = in_reset && !was_reset_reg;

	// ==========================================================
	// Instruction register
	// ==========================================================
	always_ff @(posedge tck_i)
	begin
		if (rst_sync_reg || in_reset)
			ir_reg <= sbt_pkg::IR_RESET_VAL;
		else if (upd_ir)
			ir_reg <= ir_shift_reg;
	end

	always_ff @(posedge tck_i)
	begin
		if (rst_sync_reg)
			ir_shift_reg <= sbt_pkg::IR_RESET_VAL;
		else if (cap_ir)
			ir_shift_reg <= sbt_pkg::IR_CAPTURE_VAL;
		else if (sh_ir)
			ir_shift_reg <= {tdi_i, ir_shift_reg[2:1]};
	end

	// ==========================================================
	// Skip bit
	// ==========================================================
	always_ff @(posedge tck_i)
	begin
		if (rst_sync_reg)
			skip_reg <= sbt_pkg::SKIP_CAPTURE_VAL;
		else if (upd_ir && (ir_shift_reg == sbt_pkg::INS_SKIP))
			skip_reg <= sbt_pkg::SKIP_CAPTURE_VAL;
		else if (cap_dr && skip_sel)
			skip_reg <= sbt_pkg::SKIP_CAPTURE_VAL;
		else if (sh_dr && skip_sel)
			skip_reg <= tdi_i;
	end

	// ==========================================================
	// Pin ring chain
	// ==========================================================
	// Cell 109 has no ball; it recaptures its own latched value
	always_ff @(posedge tck_i)
	begin
		if (rst_sync_reg)
			ring_shift_reg <= sbt_pkg::RING_RESET_VAL;
		else if (cap_dr && ring_sel)
			ring_shift_reg <= {ring_latch_reg[sbt_pkg::FLOAT_CELL],
				ball_sync_reg};
		else if (sh_dr && ring_sel)
			ring_shift_reg <= {tdi_i,
				ring_shift_reg[sbt_pkg::RING_W-1:1]};
	end

	always_ff @(posedge tck_i)
	begin
		if (rst_sync_reg)
			ring_latch_reg <= sbt_pkg::RING_RESET_VAL;
		else if (in_reset)
			ring_latch_reg[sbt_pkg::FLOAT_CELL] <=
				sbt_pkg::FLOAT_CELL_RESET;
		else if (upd_dr && ring_sel)
			ring_latch_reg <= ring_shift_reg;
	end

	// ==========================================================
	// Identity register
	// ==========================================================
	always_ff @(posedge tck_i)
	begin
		if (rst_sync_reg)
			ident_shift_reg <= id_value;
		else if (cap_dr && id_sel)
			ident_shift_reg <= id_value;
		else if (sh_dr && id_sel)
			ident_shift_reg <= {tdi_i,
				ident_shift_reg[sbt_pkg::ID_W-1:1]};
	end

	// ==========================================================
	// Serial output on the falling edge
	// ==========================================================
	always_ff @(negedge tck_i)
	begin
		if (rst_sync_reg)
		begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end
		else
		begin
			tdo_o    <= tdo_next;
			tdo_oe_o <= tdo_oe_next;
		end
	end

	// ==========================================================
	// Hand-off to the system clock
	// ==========================================================
	sbt_xfer_if xfer ();

	// Every change of instruction or latch raises one toggle
	always_ff @(posedge tck_i)
	begin
		if (rst_sync_reg)
		begin
			was_reset_reg <= 1'b1;
			toggle_reg    <= 1'b0;
		end
		else
		begin
			was_reset_reg <= in_reset;
			if (upd_ir || upd_dr || reset_entry)
				toggle_reg <= !toggle_reg;
		end
	end

	assign xfer.src_word   = {ir_reg, ring_latch_reg};
	assign xfer.src_toggle = toggle_reg;

	sbt_word_cross u_cross (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.xfer  (xfer.cdc)
	);

	// ==========================================================
	// Output bus control in the system domain
	// ==========================================================
	wire [2:0]                 live_ir;
	wire [sbt_pkg::RING_W-1:0] live_latch;
	wire                       live_extest;
	wire                       live_float;

	assign live_ir    = xfer.dst_word[sbt_pkg::XFER_W-1:sbt_pkg::RING_W];
	assign live_latch = xfer.dst_word[sbt_pkg::RING_W-1:0];
	assign live_extest = live_ir == sbt_pkg::INS_EXTEST;
	assign live_float = sbt_pkg::outputs_float(live_ir,
		live_latch[sbt_pkg::FLOAT_CELL]);

	// Test-port reset leaves normal memory operation untouched
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_float_o  <= 1'b0;
			test_drive_o <= 1'b0;
			test_pins_o  <= {sbt_pkg::BALL_W{1'b0}};
		end
		else
		begin
			out_float_o  <= live_float;
			test_drive_o <= live_extest;
			test_pins_o  <= live_latch[sbt_pkg::BALL_W-1:0];
		end
	end

endmodule : sbt_tap_top

/* verilog/sbt_word_cross.sv */
module sbt_word_cross (
	input wire logic clk_i,
	input wire logic rst_i,
	sbt_xfer_if.cdc  xfer
);

	// ==========================================================
	// Toggle synchroniser
	// ==========================================================
	logic                       tog_meta_reg;
	logic                       tog_sync_reg;
	logic                       tog_seen_reg;
	logic [sbt_pkg::XFER_W-1:0] word_reg;
	wire                        load_word;

	// Source word is held steady for many test-clock periods after
	// its toggle, so it is stable by the time the toggle arrives.
	assign load_word     = tog_sync_reg ^ tog_seen_reg;
	assign xfer.dst_word = word_reg;

	always_ff @(posedge clk_i)
	begin
		tog_meta_reg <= xfer.src_toggle;
		tog_sync_reg <= tog_meta_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tog_seen_reg <= 1'b0;
			word_reg     <= sbt_pkg::XFER_RESET_VAL;
		end
		else
		begin
			tog_seen_reg <= tog_sync_reg;
			if (load_word)
				word_reg <= xfer.src_word;
		end
	end

endmodule : sbt_word_cross

/* verilog/sbt_xfer_if.sv */
// Word carried from the test-clock side to the system-clock side
interface sbt_xfer_if;
	logic [sbt_pkg::XFER_W-1:0] src_word;
	logic                       src_toggle;
	logic [sbt_pkg::XFER_W-1:0] dst_word;

	modport send (output src_word, output src_toggle);
	modport cdc  (input src_word, input src_toggle, output dst_word);
	modport take (input dst_word);
endinterface : sbt_xfer_if
